// ==== include/psrc_params.svh ====
`ifndef PSRC_PARAMS_SVH
`define PSRC_PARAMS_SVH
// timing
`define PSRC_CLK_HZ 50000000
`define PSRC_TICK_HZ 32768
`define PSRC_TICK_CYC (`PSRC_CLK_HZ / `PSRC_TICK_HZ)
`define PSRC_HOLD_S 8
`define PSRC_HOLD_TICKS (`PSRC_HOLD_S * `PSRC_TICK_HZ)
// register byte offsets
`define PSRC_OFS_CTRL 5'h00
`define PSRC_OFS_STAT 5'h04
`define PSRC_OFS_SEQA 5'h08
`define PSRC_OFS_SEQD 5'h0C
`define PSRC_OFS_RES 5'h10
`define PSRC_OFS_VOLTAGE_SELECT_FIELD 5'h14
`define PSRC_OFS_CAUSE 5'h18
// device_control_reg fields
`define PSRC_B_KEEP 0
`define PSRC_B_AUTO 1
`define PSRC_B_GATE 2
`define PSRC_B_HWLVL 3
`define PSRC_B_CR 4
// voltage register fields
`define PSRC_VF_LO 8
// switch_off_cause_reg fields
`define PSRC_C_TMO 0
`define PSRC_C_REL 1
// reset values
`define PSRC_CFG_RST 4'h1
`define PSRC_VOLTAGE_SELECT_FIELD_SET0 7'h28
`define PSRC_VOLTAGE_SELECT_FIELD_SET1 7'h32
`define PSRC_STEP_ON 16'h8201
`define PSRC_STEP_OFF 16'h8002
`endif

// ==== include/psrc_pkg.sv ====
package psrc_pkg;
  localparam int NRES = 8;
  typedef enum logic [3:0] {
    PSRC_OFF = 4'h1,
    PSRC_UP = 4'h2,
    PSRC_ACT = 4'h4,
    PSRC_DOWN = 4'h8
  } psrc_state_t;
  typedef enum logic [1:0] {
    PSRC_M_OFF = 2'h0,
    PSRC_M_ON = 2'h1,
    PSRC_M_SLP = 2'h2,
    PSRC_M_RSV = 2'h3
  } psrc_mode_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } psrc_bus_req_t;
  // one sequence step; on a branch step res[0] picks the boot pin,
  // mode[0] is the level to match and dly holds the target index
  typedef struct packed {
    logic last;
    logic br;
    logic [2:0] res;
    psrc_mode_t mode;
    logic [8:0] dly;
  } psrc_step_t;
endpackage

// ==== verilog/psrc_sync.sv ====
`timescale 1ns/1ps
module psrc_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // two-flop synchroniser, first stage feeds only the second
  always_ff @(posedge mclk) begin
    meta <= din;
    dout <= meta;
  end
endmodule

// ==== verilog/psrc_ctrl.sv ====
`timescale 1ns/1ps
`include "psrc_params.svh"
module psrc_ctrl #(
  parameter int DEPTH = 16,
  parameter int TICK_CYC = `PSRC_TICK_CYC,
  parameter int HOLD_TICKS = `PSRC_HOLD_TICKS
) (
  input wire logic mclk,
  input wire logic srst,
  input wire psrc_pkg::psrc_bus_req_t busReq,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic powerButtonInput,
  input wire logic holdPowerPin,
  input wire logic bootSelectFirst,
  input wire logic bootSelectSecond,
  input wire logic xtalStable,
  input wire logic ext32kStable,
  input wire logic xtalBypass,
  input wire logic onGate,
  output logic resetOut,
  output logic [2*psrc_pkg::NRES-1:0] resourceMode,
  output logic [6:0] buckVoltage,
  output logic [6:0] buckForced,
  output logic seqBusy
);
  localparam int AW = $clog2(4 * DEPTH);
  localparam logic [AW-1:0] BASE1 = AW'(DEPTH);
  localparam logic [AW-1:0] BASE2 = AW'(2 * DEPTH);
  localparam logic [AW-1:0] BASE_OFF = AW'(3 * DEPTH);
  localparam int RW = 2 * psrc_pkg::NRES;

  // pin synchronisers
  logic [7:0] pinSync;
  wire btn = pinSync[0];
  wire hold = pinSync[1];
  wire boot_select_first = pinSync[2];
  wire boot_select_second = pinSync[3];
  wire xtalOk = pinSync[4];
  wire ext32kOk = pinSync[5];
  wire bypass = pinSync[6];
  wire gate = pinSync[7];

  psrc_sync #(
    .W(8)
  ) psrc_sync_i (
    .mclk(mclk),
    .din({onGate, xtalBypass, ext32kStable, xtalStable,
          bootSelectSecond, bootSelectFirst, holdPowerPin,
          powerButtonInput}),
    .dout(pinSync)
  );

  // state
  psrc_pkg::psrc_state_t state;
  psrc_pkg::psrc_step_t mem [4*DEPTH];
  psrc_pkg::psrc_step_t step;
  logic [AW-1:0] pc;
  logic [AW-1:0] seqAddr;
  logic [8:0] dly;
  logic seqEnd;
  logic [15:0] tickCnt;
  logic [23:0] holdCnt;
  logic ackSeen;
  logic btnPrev;
  logic keepOn;
  logic [3:0] cfg;
  logic offHw;
  logic offCr;
  logic restartPend;
  logic hardware_reset_level;
  logic switchoff_reset_level;
  logic [1:0] cause;
  logic busAck;
  logic [31:0] rdMux;

  // reset domains
  wire domHw = srst | hardware_reset_level;
  wire domSwo = domHw | switchoff_reset_level;

  // decode
  wire busReqAny = busReq.read | busReq.write;
  wire wrEn = busReq.write & busAck;
  wire [31:0] wd = busReq.writedata;
  wire [4:0] adr = busReq.address;
  wire wrCtrl = wrEn & (adr == `PSRC_OFS_CTRL);
  wire wrSeqa = wrEn & (adr == `PSRC_OFS_SEQA);
  wire wrSeqd = wrEn & (adr == `PSRC_OFS_SEQD);
  wire wrRes = wrEn & (adr == `PSRC_OFS_RES);
  wire wrVsel = wrEn & (adr == `PSRC_OFS_VOLTAGE_SELECT_FIELD);

  wire cfgAuto = cfg[`PSRC_B_AUTO-1];
  wire cfgGate = cfg[`PSRC_B_GATE-1];
  wire cfgHwLvl = cfg[`PSRC_B_HWLVL-1];
  wire cfgCr = cfg[`PSRC_B_CR-1];

  wire stOff = state == psrc_pkg::PSRC_OFF;
  wire stUp = state == psrc_pkg::PSRC_UP;
  wire stAct = state == psrc_pkg::PSRC_ACT;
  wire stDown = state == psrc_pkg::PSRC_DOWN;

  // sequencer control
  wire tick = tickCnt == 16'(TICK_CYC - 1);
  wire seqIdle = dly == 9'h000;
  wire stepExec = seqBusy & seqIdle & !seqEnd;
  wire upDone = stUp & seqIdle & seqEnd;
  wire downDone = stDown & seqIdle & seqEnd;
  wire brTaken = (step.res[0] ? boot_select_second : boot_select_first) == step.mode[0];
  wire [AW-1:0] upBase = boot_select_first ? BASE2 : (boot_select_second ? BASE1 : '0);
  wire btnRise = btn & !btnPrev;
  wire startReq = stOff & (btnRise | restartPend) & !gate;
  wire clkOk = cfgGate | (bypass ? ext32kOk : xtalOk);

  // acknowledge: either the hold pin or the keep-on bit holds power
  wire keepLvl = hold | keepOn;
  wire holdDone = holdCnt == 24'(HOLD_TICKS);
  wire offReq = stAct & (ackSeen ? !keepLvl : holdDone);

  assign step = mem[pc];
  assign seqBusy = stUp | stDown;
  assign waitrequest = busReqAny & !busAck;

  assign rdMux =
    (adr == `PSRC_OFS_CTRL) ? {27'h0000000, cfg, keepOn} :
    (adr == `PSRC_OFS_STAT) ?
      {23'h000000, clkOk, boot_select_second, boot_select_first, ackSeen, resetOut, state} :
    (adr == `PSRC_OFS_SEQA) ? {{(32-AW){1'b0}}, seqAddr} :
    (adr == `PSRC_OFS_SEQD) ? {16'h0000, mem[seqAddr]} :
    (adr == `PSRC_OFS_RES) ? {{(32-RW){1'b0}}, resourceMode} :
    (adr == `PSRC_OFS_VOLTAGE_SELECT_FIELD) ? {17'h00000, buckForced, 1'b0, buckVoltage} :
    (adr == `PSRC_OFS_CAUSE) ? {30'h00000000, cause} :
    32'h00000000;

  // bus slave: one wait cycle, read data captured while waiting
  always_ff @(posedge mclk) begin
    if (srst) begin
      busAck <= 1'b0;
    end else begin
      busAck <= busReqAny & !busAck;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      readdata <= 32'h00000000;
    end else if (busReq.read & !busAck) begin
      readdata <= rdMux;
    end
  end

  // 32 kHz time base
  always_ff @(posedge mclk) begin
    if (srst || tick) begin
      tickCnt <= 16'h0000;
    end else begin
      tickCnt <= tickCnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      btnPrev <= 1'b0;
    end else begin
      btnPrev <= btn;
    end
  end

  // power state machine
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= psrc_pkg::PSRC_OFF;
    end else begin
      case (state)
        psrc_pkg::PSRC_OFF: begin
          if (startReq) begin
            state <= psrc_pkg::PSRC_UP;
          end
        end
        psrc_pkg::PSRC_UP: begin
          if (upDone) begin
            state <= psrc_pkg::PSRC_ACT;
          end
        end
        psrc_pkg::PSRC_ACT: begin
          if (offReq) begin
            state <= psrc_pkg::PSRC_DOWN;
          end
        end
        psrc_pkg::PSRC_DOWN: begin
          if (downDone) begin
            state <= psrc_pkg::PSRC_OFF;
          end
        end
        default: begin
          state <= psrc_pkg::PSRC_OFF;
        end
      endcase
    end
  end

  // step engine
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc <= '0;
      dly <= 9'h000;
      seqEnd <= 1'b0;
    end else if (startReq) begin
      pc <= upBase;
      dly <= 9'h000;
      seqEnd <= 1'b0;
    end else if (offReq) begin
      pc <= BASE_OFF;
      dly <= 9'h000;
      seqEnd <= 1'b0;
    end else if (seqBusy && !seqIdle) begin
      if (tick) begin
        dly <= dly - 9'h001;
      end
    end else if (stepExec && step.br) begin
      pc <= brTaken ? step.dly[AW-1:0] : pc + AW'(1);
    end else if (stepExec) begin
      dly <= step.dly;
      seqEnd <= step.last;
      pc <= pc + AW'(1);
    end
  end

  // resource modes: sequence writes, then software once active
  always_ff @(posedge mclk) begin
    if (domSwo) begin
      resourceMode <= '0;
    end else if (stepExec && !step.br) begin
      resourceMode[{step.res, 1'b0} +: 2] <= step.mode;
    end else if (wrRes && stAct) begin
      resourceMode <= wd[RW-1:0];
    end
  end

  // buck voltages share one boot-selected reset value
  always_ff @(posedge mclk) begin
    if (domSwo) begin
      buckVoltage <= boot_select_first ? `PSRC_VOLTAGE_SELECT_FIELD_SET1 : `PSRC_VOLTAGE_SELECT_FIELD_SET0;
      buckForced <= boot_select_first ? `PSRC_VOLTAGE_SELECT_FIELD_SET1 : `PSRC_VOLTAGE_SELECT_FIELD_SET0;
    end else if (wrVsel) begin
      buckVoltage <= wd[6:0];
      buckForced <= wd[`PSRC_VF_LO +: 7];
    end
  end

  // keep-on bit: hardware set wins over a clearing write
  always_ff @(posedge mclk) begin
    if (domSwo) begin
      keepOn <= 1'b0;
    end else if (upDone && cfgAuto) begin
      keepOn <= 1'b1;
    end else if (wrCtrl) begin
      keepOn <= wd[`PSRC_B_KEEP];
    end
  end

  always_ff @(posedge mclk) begin
    if (domHw) begin
      cfg <= `PSRC_CFG_RST;
    end else if (wrCtrl) begin
      cfg <= wd[`PSRC_B_CR:`PSRC_B_AUTO];
    end
  end

  // sequence store
  always_ff @(posedge mclk) begin
    if (domHw) begin
      seqAddr <= '0;
    end else if (wrSeqa) begin
      seqAddr <= wd[AW-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (domHw) begin
      for (int i = 0; i < 4 * DEPTH; i++) begin
        mem[i] <= (i >= 3 * DEPTH) ? `PSRC_STEP_OFF : `PSRC_STEP_ON;
      end
    end else if (wrSeqd && !seqBusy) begin
      mem[seqAddr] <= wd[15:0];
    end
  end

  // acknowledge window in active
  always_ff @(posedge mclk) begin
    if (srst || !stAct) begin
      holdCnt <= 24'h000000;
      ackSeen <= 1'b0;
    end else begin
      if (tick && !holdDone) begin
        holdCnt <= holdCnt + 24'h000001;
      end
      if (keepLvl) begin
        ackSeen <= 1'b1;
      end
    end
  end

  // off request latches and reset pulses
  always_ff @(posedge mclk) begin
    if (srst) begin
      offHw <= 1'b0;
      offCr <= 1'b0;
    end else if (offReq) begin
      offHw <= cfgHwLvl;
      offCr <= cfgCr;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      hardware_reset_level <= 1'b0;
      switchoff_reset_level <= 1'b0;
    end else begin
      hardware_reset_level <= downDone & offHw;
      switchoff_reset_level <= downDone & !offHw;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      restartPend <= 1'b0;
    end else if (downDone) begin
      restartPend <= offCr;
    end else if (stOff) begin
      restartPend <= 1'b0;
    end
  end

  // power-on domain: cause, cleared only by srst
  always_ff @(posedge mclk) begin
    if (srst) begin
      cause <= 2'h0;
    end else if (offReq) begin
      cause[`PSRC_C_TMO] <= cause[`PSRC_C_TMO] | !ackSeen;
      cause[`PSRC_C_REL] <= cause[`PSRC_C_REL] | ackSeen;
    end
  end

  // processor reset release
  always_ff @(posedge mclk) begin
    if (srst) begin
      resetOut <= 1'b0;
    end else begin
      resetOut <= stAct & clkOk & !offReq;
    end
  end
endmodule

// ==== testbench/psrc_ctrl_assertions.sv ====
`timescale 1ns/1ps
`include "psrc_params.svh"
module psrc_ctrl_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire psrc_pkg::psrc_bus_req_t busReq,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic bootSelectFirst,
  input wire logic resetOut,
  input wire logic [2*psrc_pkg::NRES-1:0] resourceMode,
  input wire logic [6:0] buckVoltage,
  input wire logic [6:0] buckForced,
  input wire logic seqBusy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire rq = busReq.read | busReq.write;
  wire rdAck = busReq.read & !waitrequest;
  wire wrRes = busReq.write & !waitrequest & (busReq.address == 5'h10);
  AST_ACK: assert property (rq && waitrequest |=> !waitrequest)
    else $error("no answer one cycle after request");
  AST_IDLE: assert property (!rq |-> !waitrequest)
    else $error("wait without request");
  AST_UNMAP: assert property (rdAck && busReq.address == 5'h1C
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  AST_STAT: assert property (rdAck && busReq.address == 5'h04 |->
    readdata[4] == $past(resetOut) && $onehot(readdata[3:0]))
    else $error("status read wrong");
  AST_RST: assert property ($fell(srst) |-> !resetOut && !seqBusy
    && resourceMode == '0 && buckVoltage == buckForced
    && buckVoltage == (bootSelectFirst ? `PSRC_VOLTAGE_SELECT_FIELD_SET1 :
    `PSRC_VOLTAGE_SELECT_FIELD_SET0)) else $error("reset values wrong");
  AST_BUSY: assert property (resetOut |-> !seqBusy)
    else $error("reset released during sequence");
  AST_ROSE: assert property ($rose(resetOut) |-> !$past(seqBusy))
    else $error("reset released before sequence end");
  AST_MODE: assert property ($changed(resourceMode) |->
    $past(seqBusy) || $past(seqBusy, 2) || $past(wrRes))
    else $error("resource mode changed outside sequence");
endmodule
bind psrc_ctrl psrc_ctrl_chk psrc_ctrl_chk_i (.mclk, .srst, .busReq,
  .readdata, .waitrequest, .bootSelectFirst, .resetOut, .resourceMode,
  .buckVoltage, .buckForced, .seqBusy);

// ==== testbench/psrc_host_model.sv ====
`timescale 1ns/1ps
module psrc_host_model (
  input wire logic mclk,
  input wire logic resetOut,
  input wire logic keep,
  output logic holdPowerPin
);
  logic [3:0] cnt = 4'h0;
  initial holdPowerPin = 1'b0;
  // raise hold some cycles after reset release, drop when told
  always @(posedge mclk) begin
    cnt <= resetOut ? cnt + {3'h0, cnt != 4'hF} : 4'h0;
    holdPowerPin <= keep && (holdPowerPin || cnt == 4'h8);
  end
endmodule

// ==== testbench/psrc_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "psrc_params.svh"
`define CHK(s, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("unexpected %s exp %0h got %0h", s, e, g); \
  end \
end
module psrc_ctrl_tb;
  localparam int TK = 4;
  localparam int HT = 20;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  psrc_pkg::psrc_bus_req_t busReq = '0;
  logic powerButtonInput = 1'b0, bootSelectFirst = 1'b0;
  logic bootSelectSecond = 1'b0, xtalStable = 1'b1, onGate = 1'b0;
  logic ext32kStable = 1'b0, xtalBypass = 1'b0;
  logic keep = 1'b0;
  logic [31:0] readdata, rd;
  logic waitrequest, resetOut, seqBusy, holdPowerPin;
  logic [15:0] resourceMode;
  logic [6:0] buckVoltage, buckForced;
  int n_errors = 0;
  int checks = 0;
  int n;
  logic [5:0] adr [4] = '{6'h00, 6'h10, 6'h12, 6'h20};
  logic [15:0] wd [4] = '{16'h9A01, 16'h4A12, 16'h9201, 16'h8C01};
  logic [15:0] expm [3] = '{16'h0040, 16'h0010, 16'h0008};
  psrc_ctrl #(.TICK_CYC(TK), .HOLD_TICKS(HT)) psrc_ctrl_i (.mclk, .srst,
    .busReq, .readdata, .waitrequest, .powerButtonInput, .holdPowerPin,
    .bootSelectFirst, .bootSelectSecond, .xtalStable, .ext32kStable,
    .xtalBypass, .onGate, .resetOut, .resourceMode, .buckVoltage,
    .buckForced, .seqBusy);
  psrc_host_model psrc_host_model_i (.mclk, .resetOut, .keep,
    .holdPowerPin);
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    busReq <= '{!w, w, a, d};
    do begin
      @(posedge mclk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_errors++;
      give_verdict();
    end
    rd = readdata;
    busReq <= '0;
    @(posedge mclk);
  endtask
  task automatic rchk(input string s, input logic [4:0] a,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(s, e, rd)
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic press();
    powerButtonInput <= 1'b1;
    idle(4);
    powerButtonInput <= 1'b0;
  endtask
  // s 0 watches resetOut, s 1.. watches resource mode field s-1
  task automatic waitv(input int s, input logic [1:0] v);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((s == 0 ? {1'b0, resetOut} : resourceMode[2*s-1 -: 2])
      !== v && n < 400);
    if (n >= 400) begin
      n_errors++;
      give_verdict();
    end
    @(posedge mclk);
  endtask
  initial begin
    idle(4);
    srst <= 1'b0;
    idle(1);
    rchk("voltage_select_field", `PSRC_OFS_VOLTAGE_SELECT_FIELD, 32'h2828);
    rchk("ctrl", `PSRC_OFS_CTRL, 32'h2);
    rchk("cause", `PSRC_OFS_CAUSE, 32'h0);
    rchk("unmapped", 5'h1C, 32'h0);
    onGate <= 1'b1;
    idle(3);
    press();
    idle(30);
    `CHK("gated", 1'b0, seqBusy)
    onGate <= 1'b0;
    idle(3);
    press();
    waitv(0, 2'h1);
    `CHK("modes", 16'h0001, resourceMode)
    rchk("ctrl", `PSRC_OFS_CTRL, 32'h3);
    rchk("stat", `PSRC_OFS_STAT, 32'h134);
    bus(1'b1, `PSRC_OFS_RES, 32'h5);
    `CHK("res", 16'h0005, resourceMode)
    bus(1'b1, `PSRC_OFS_VOLTAGE_SELECT_FIELD, 32'h3355);
    `CHK("forced", 7'h33, buckForced)
    `CHK("volt", 7'h55, buckVoltage)
    rchk("voltage_select_field", `PSRC_OFS_VOLTAGE_SELECT_FIELD, 32'h3355);
    idle(150);
    `CHK("stay", 1'b1, resetOut)
    bus(1'b1, `PSRC_OFS_CTRL, 32'h6);
    waitv(0, 2'h0);
    idle(40);
    `CHK("res off", 16'h0, resourceMode)
    rchk("voltage_select_field", `PSRC_OFS_VOLTAGE_SELECT_FIELD, 32'h2828);
    rchk("ctrl", `PSRC_OFS_CTRL, 32'h6);
    rchk("cause", `PSRC_OFS_CAUSE, 32'h2);
    xtalStable <= 1'b0;
    bus(1'b1, `PSRC_OFS_CTRL, 32'h4);
    press();
    waitv(0, 2'h1);
    waitv(0, 2'h0);
    `CHK("hold", 1'b1, n >= HT*TK-8 && n <= HT*TK+TK+8)
    idle(40);
    rchk("cause", `PSRC_OFS_CAUSE, 32'h3);
    xtalStable <= 1'b1;
    bus(1'b1, `PSRC_OFS_SEQA, 32'h0);
    bus(1'b1, `PSRC_OFS_SEQD, 32'h0A03);
    bus(1'b1, `PSRC_OFS_SEQA, 32'h1);
    bus(1'b1, `PSRC_OFS_SEQD, 32'h8201);
    rchk("step", `PSRC_OFS_SEQD, 32'h8201);
    bus(1'b1, `PSRC_OFS_CTRL, 32'h8);
    keep <= 1'b1;
    press();
    waitv(2, 2'h1);
    waitv(1, 2'h1);
    `CHK("gap", 1'b1, n >= 2*TK && n <= 4*TK+2)
    waitv(0, 2'h1);
    idle(150);
    `CHK("held", 1'b1, resetOut)
    keep <= 1'b0;
    waitv(0, 2'h0);
    idle(40);
    rchk("ctrl", `PSRC_OFS_CTRL, 32'h2);
    rchk("seqa", `PSRC_OFS_SEQA, 32'h0);
    rchk("step", `PSRC_OFS_SEQD, 32'h8201);
    rchk("cause", `PSRC_OFS_CAUSE, 32'h3);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `PSRC_OFS_SEQA, {26'h0, adr[i]});
      bus(1'b1, `PSRC_OFS_SEQD, {16'h0, wd[i]});
    end
    for (int i = 0; i < 3; i++) begin
      bootSelectFirst <= i[1];
      bootSelectSecond <= i[0];
      idle(4);
      press();
      waitv(0, 2'h1);
      `CHK("boot", expm[i], resourceMode)
      bus(1'b1, `PSRC_OFS_CTRL, 32'h2);
      waitv(0, 2'h0);
      idle(40);
    end
    rchk("voltage_select_field", `PSRC_OFS_VOLTAGE_SELECT_FIELD, 32'h3232);
    xtalBypass <= 1'b1;
    press();
    idle(60);
    `CHK("bypass", 1'b0, resetOut)
    rchk("stat", `PSRC_OFS_STAT, 32'h64);
    ext32kStable <= 1'b1;
    waitv(0, 2'h1);
    bus(1'b1, `PSRC_OFS_CTRL, 32'h12);
    waitv(0, 2'h0);
    waitv(0, 2'h1);
    rchk("ctrl", `PSRC_OFS_CTRL, 32'h13);
    give_verdict();
  end
endmodule
